// File: inc/cit_pkg.sv
// Constants and register map for the compare interval timer
package cit_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] CIT_OFF_COUNT_CTRL  = 6'h00; // count_control_reg
  localparam logic [5:0] CIT_OFF_UNIT_MODE   = 6'h04; // unit_mode_reg
  localparam logic [5:0] CIT_OFF_OUT_CTRL    = 6'h08; // output_control_reg
  localparam logic [5:0] CIT_OFF_PRESCALE    = 6'h0c; // prescale_select_reg
  localparam logic [5:0] CIT_OFF_CMP_A       = 6'h10; // compare_reg_a
  localparam logic [5:0] CIT_OFF_CMP_B       = 6'h14; // compare_reg_b
  localparam logic [5:0] CIT_OFF_COUNTER     = 6'h18; // up_counter_main (RO)
  localparam logic [5:0] CIT_OFF_IRQ_STATUS  = 6'h1c; // W1C sticky flags
  localparam logic [5:0] CIT_OFF_IRQ_MASK    = 6'h20; // 1 = enabled

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CIT_CE_BIT     = 0; // count_enable_bit
  localparam int CIT_CLR_BIT    = 0; // unit mode: clear on match a
  localparam int CIT_SR_BIT     = 1; // unit mode: set/reset on wave a
  localparam int CIT_ENA_BIT    = 0; // pulse_output_enable_bit a
  localparam int CIT_ALVA_BIT   = 1; // active_level_bit a
  localparam int CIT_ENB_BIT    = 2; // pulse_output_enable_bit b
  localparam int CIT_ALVB_BIT   = 3; // active_level_bit b
  localparam int CIT_IRQ_MA_BIT = 0; // match_a_request_flag
  localparam int CIT_IRQ_MB_BIT = 1; // match_b_request_flag
  localparam int CIT_IRQ_OV_BIT = 2; // overflow request flag

  // ---------------------------------------------------------------
  // Widths, reset values, timing
  // ---------------------------------------------------------------
  localparam int          CIT_CNT_W      = 16;
  localparam int          CIT_PSC_W      = 7;   // divide up to 128
  localparam logic [2:0]  CIT_PSC_MAX    = 3'h4;
  localparam logic [15:0] CIT_CNT_RST    = 16'h0000;
  localparam logic [15:0] CIT_CNT_START  = 16'h0001;
  localparam logic [15:0] CIT_CNT_TOP    = 16'hffff;
  localparam logic [1:0]  CIT_RESP_OKAY  = 2'b00;
  localparam logic [1:0]  CIT_RESP_SLVERR = 2'b10;

endpackage

// File: src/cit_prescaler.sv
// Shared prescaler time base producing count clock enables
`timescale 1ns/10ps
module cit_prescaler
  import cit_pkg::*;
#(
  parameter int PSC_W = CIT_PSC_W
)
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic [2:0] sel,
  output logic            tick
);

  typedef struct packed {
    logic [PSC_W-1:0] base;
    logic             tick;
  } cit_psc_st_t;

  cit_psc_st_t s_q;
  cit_psc_st_t s_d;
  logic [PSC_W-1:0] mask;

  always_comb
  begin
    // Divide by 8 << sel, at most 128, so mask low min(3+sel, PSC_W) bits
    mask = PSC_W'((8 << sel) - 1);
    s_d = s_q;
    s_d.tick = 1'b0;
    if (run)
    begin
      s_d.base = s_q.base + 1'b1;
      // Fires once per divided period of the free base
      if ((s_q.base & mask) == mask)
        s_d.tick = 1'b1;
    end
    else
    begin
      s_d.base = '0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign tick = s_q.tick;

endmodule // cit_prescaler

// File: src/cit_timer.sv
// Compare interval timer with AXI4-Lite register slave
`timescale 1ns/10ps
module cit_timer
  import cit_pkg::*;
#(
  parameter int CNT_W = CIT_CNT_W
)
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             wave_out_a,
  output logic             wave_out_b,
  output logic             irq
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic             awready;
    logic             wready;
    logic [5:0]       awaddr;
    logic             aw_held;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             w_held;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             arready;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic             count_enable_bit;
    logic             started;
    logic [1:0]       unit_mode_reg;
    logic [3:0]       output_control_reg;
    logic [2:0]       prescale_select_reg;
    logic [CNT_W-1:0] compare_reg_a;
    logic [CNT_W-1:0] compare_reg_b;
    logic [CNT_W-1:0] up_counter_main;
    logic             clr_pend;
    logic [2:0]       irq_status;
    logic [2:0]       irq_mask;
    logic             wave_a;
    logic             wave_b;
    logic             irq;
  } cit_st_t;

  cit_st_t s_q;
  cit_st_t s_d;
  logic    tick;
  logic    base_run_q;

  // ---------------------------------------------------------------
  // Shared time base
  // ---------------------------------------------------------------
  // shared base
  // Base starts with the first enable and then runs freely
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      base_run_q <= 1'b0;
    else if (s_q.count_enable_bit)
      base_run_q <= 1'b1;
  end

  cit_prescaler u_psc (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (base_run_q | s_q.count_enable_bit),
    .sel     (s_q.prescale_select_reg),
    .tick    (tick)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic             do_wr;
    logic             inc;
    logic             mat_a;
    logic             mat_b;
    logic [CNT_W-1:0] nxt;
    logic [31:0]      wd;
    logic [2:0]       w1c;
    logic [2:0]       ev;
    do_wr = 1'b0;
    inc   = 1'b0;
    mat_a = 1'b0;
    mat_b = 1'b0;
    nxt   = '0;
    wd    = '0;
    w1c   = '0;
    ev    = '0;
    s_d   = s_q;

    // Write channel capture, either order
    if (s_q.awready && s_axi_awvalid)
    begin
      s_d.awaddr  = s_axi_awaddr;
      s_d.aw_held = 1'b1;
      s_d.awready = 1'b0;
    end
    if (s_q.wready && s_axi_wvalid)
    begin
      s_d.wdata  = s_axi_wdata;
      s_d.wstrb  = s_axi_wstrb;
      s_d.w_held = 1'b1;
      s_d.wready = 1'b0;
    end
    if (s_q.aw_held && s_q.w_held && !s_q.bvalid)
    begin
      do_wr       = 1'b1;
      s_d.aw_held = 1'b0;
      s_d.w_held  = 1'b0;
      s_d.bvalid  = 1'b1;
      s_d.bresp   = CIT_RESP_OKAY;
    end
    if (s_q.bvalid && s_axi_bready)
    begin
      s_d.bvalid  = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready  = 1'b1;
    end

    // Byte lanes without strobe write as zero
    for (int i = 0; i < 4; i++)
      wd[8*i +: 8] = s_q.wstrb[i] ? s_q.wdata[8*i +: 8] : 8'h00;

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    if (s_q.count_enable_bit && tick)
    begin
      if (!s_q.started || s_q.clr_pend)
        nxt = s_q.clr_pend ? CNT_W'(CIT_CNT_RST) : CNT_W'(CIT_CNT_START);
      else
        nxt = s_q.up_counter_main + 1'b1;
      if (!s_q.started && !s_q.clr_pend)
        nxt = CNT_W'(CIT_CNT_START);
      inc = 1'b1;
      s_d.started = 1'b1;
      s_d.up_counter_main = nxt;
      s_d.clr_pend = 1'b0;
      if (s_q.started && !s_q.clr_pend &&
          s_q.up_counter_main == CNT_W'(CIT_CNT_TOP))
        ev[CIT_IRQ_OV_BIT] = 1'b1;
    end
    if (inc)
    begin
      mat_a = (nxt == s_q.compare_reg_a);
      mat_b = (nxt == s_q.compare_reg_b);
    end
    if (mat_a && s_q.unit_mode_reg[CIT_CLR_BIT])
      s_d.clr_pend = 1'b1;
    ev[CIT_IRQ_MA_BIT] = mat_a;
    ev[CIT_IRQ_MB_BIT] = mat_b;

    // Output control: toggle or set/reset
    // match drives pin
    if (s_q.unit_mode_reg[CIT_SR_BIT])
    begin
      if (mat_a)
        s_d.wave_a = 1'b1;
      else if (mat_b)
        s_d.wave_a = 1'b0;
    end
    else if (mat_a)
      s_d.wave_a = !s_q.wave_a;
    if (mat_b)
      s_d.wave_b = !s_q.wave_b;

    // ---------------------------------------------------------------
    // Register writes
    // ---------------------------------------------------------------
    if (do_wr)
    begin
      case (s_q.awaddr)
        CIT_OFF_COUNT_CTRL:
        begin
          s_d.count_enable_bit = wd[CIT_CE_BIT];
          if (!wd[CIT_CE_BIT])
          begin
            s_d.up_counter_main = CNT_W'(CIT_CNT_RST);
            s_d.started  = 1'b0;
            s_d.clr_pend = 1'b0;
          end
        end
        CIT_OFF_UNIT_MODE:  s_d.unit_mode_reg       = wd[1:0];
        CIT_OFF_OUT_CTRL:   s_d.output_control_reg  = wd[3:0];
        CIT_OFF_PRESCALE:   s_d.prescale_select_reg = wd[2:0];
        CIT_OFF_CMP_A:      s_d.compare_reg_a = wd[CNT_W-1:0];
        CIT_OFF_CMP_B:      s_d.compare_reg_b = wd[CNT_W-1:0];
        CIT_OFF_IRQ_STATUS: w1c = wd[2:0];
        CIT_OFF_IRQ_MASK:   s_d.irq_mask = wd[2:0];
        default:            s_d.bresp = CIT_RESP_SLVERR;
      endcase
    end

    // match survives stop
    // Set wins over write-one clear
    s_d.irq_status = (s_q.irq_status & ~w1c) | ev;
    s_d.irq = |(s_d.irq_status & s_d.irq_mask);

    // ---------------------------------------------------------------
    // Read channel
    // ---------------------------------------------------------------
    if (s_q.arready && s_axi_arvalid)
    begin
      s_d.arready = 1'b0;
      s_d.rvalid  = 1'b1;
      s_d.rresp   = CIT_RESP_OKAY;
      s_d.rdata   = '0;
      case (s_axi_araddr)
        CIT_OFF_COUNT_CTRL: s_d.rdata[0]   = s_q.count_enable_bit;
        CIT_OFF_UNIT_MODE:  s_d.rdata[1:0] = s_q.unit_mode_reg;
        CIT_OFF_OUT_CTRL:   s_d.rdata[3:0] = s_q.output_control_reg;
        CIT_OFF_PRESCALE:   s_d.rdata[2:0] = s_q.prescale_select_reg;
        CIT_OFF_CMP_A:      s_d.rdata[CNT_W-1:0] = s_q.compare_reg_a;
        CIT_OFF_CMP_B:      s_d.rdata[CNT_W-1:0] = s_q.compare_reg_b;
        CIT_OFF_COUNTER:    s_d.rdata[CNT_W-1:0] = s_q.up_counter_main;
        CIT_OFF_IRQ_STATUS: s_d.rdata[2:0] = s_q.irq_status;
        CIT_OFF_IRQ_MASK:   s_d.rdata[2:0] = s_q.irq_mask;
        default:            s_d.rresp = CIT_RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready)
    begin
      s_d.rvalid  = 1'b0;
      s_d.arready = 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_q         <= '0;
      s_q.awready <= 1'b1;
      s_q.wready  <= 1'b1;
      s_q.arready <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // ---------------------------------------------------------------
  // Pins: disabled output holds inverse of active level
  // ---------------------------------------------------------------
  logic wave_a_pin_q;
  logic wave_b_pin_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wave_a_pin_q <= 1'b1;
      wave_b_pin_q <= 1'b1;
    end
    else
    begin
      wave_a_pin_q <= s_d.output_control_reg[CIT_ENA_BIT] ? s_d.wave_a :
                      !s_d.output_control_reg[CIT_ALVA_BIT];
      wave_b_pin_q <= s_d.output_control_reg[CIT_ENB_BIT] ? s_d.wave_b :
                      !s_d.output_control_reg[CIT_ALVB_BIT];
    end
  end

  assign s_axi_awready = s_q.awready;
  assign s_axi_wready  = s_q.wready;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign wave_out_a    = wave_a_pin_q;
  assign wave_out_b    = wave_b_pin_q;
  assign irq           = s_q.irq;

endmodule // cit_timer

// File: testbench/cit_timer_checker.sv
// Bus and output assertions for the compare interval timer
`timescale 1ns/10ps
module cit_timer_checker
  import cit_pkg::*;
#(
  parameter int CNT_W = CIT_CNT_W
)
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        wave_out_a,
  input wire logic        wave_out_b,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RST_OUT: assert property ($rose(aresetn) |->
    !irq && wave_out_a && wave_out_b) else $error("reset state wrong");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("bvalid dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read not held");
  AST_AW_BLOCK: assert property (s_axi_awvalid && s_axi_awready |=>
    !s_axi_awready) else $error("awready not dropped");
  AST_AR_LAT: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read late");
  AST_W_LAT: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer timing");
  AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write not closed");
  AST_RERR: assert property (s_axi_rvalid && s_axi_rresp == CIT_RESP_SLVERR
    |-> s_axi_rdata == 32'h0) else $error("error read data");

  COV_IRQ: cover property ($rose(irq));
  COV_WAVE: cover property ($changed(wave_out_a));
  COV_BERR: cover property (s_axi_bvalid && s_axi_bresp == CIT_RESP_SLVERR);
endmodule // cit_timer_checker

bind cit_timer cit_timer_checker #(.CNT_W(CNT_W)) u_chk (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .s_axi_rresp, .wave_out_a, .wave_out_b, .irq);

// File: testbench/tb_top.sv
// Self-checking bench for the compare interval timer
`timescale 1ns/10ps
module tb_top;
  import cit_pkg::*;
  logic        aclk, aresetn, awv, wv, arv, awr, wr_r, bv, arr, rv;
  logic [5:0]  awa, ara;
  logic [31:0] wd, rdat, rd_v, cmp_b;
  logic [1:0]  br, rr, resp;
  logic        wa, wb, irq, w0;
  logic        brd, rrd;
  integer      seed;
  int          n_fail, checked, cyc, t0, t1, n;
  int          mdl [0:8];
  localparam int TB_CNT_W = 8;
  // Writable bits per register; status and counter not modelled
  logic [31:0] rw_mask [0:8] = '{32'h1, 32'h3, 32'hf, 32'h7,
    32'((1 << TB_CNT_W) - 1), 32'((1 << TB_CNT_W) - 1),
    32'h0, 32'h0, 32'h7};

  cit_timer #(.CNT_W(TB_CNT_W)) uut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(brd), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rrd), .wave_out_a(wa),
    .wave_out_b(wb), .irq(irq));

  // ---------------------------------------------------------------
  // Clock, cycle count, watchdog
  // ---------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  always @(posedge aclk) cyc <= cyc + 1;
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    end_of_test;
  end

  // ---------------------------------------------------------------
  // Bus tasks and compare
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    int k;
    int dl;
    k = 0;
    dl = 1 + int'($unsigned($random(seed)) % 4);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (awr)
        awv <= 1'b0;
      if (wr_r)
        wv <= 1'b0;
      if (k >= dl && brd !== 1'b1)
        brd <= 1'b1;
    end while (!(bv === 1'b1 && brd === 1'b1) && k < 50);
    brd <= 1'b0;
    resp = br;
    chk(32'(k >= 50), 32'h0);
    if (a < 6'h24)
      mdl[a[5:2]] = int'(d & rw_mask[a[5:2]]);
  endtask
  task automatic rd(input logic [5:0] a);
    int k;
    int dl;
    k = 0;
    dl = 1 + int'($unsigned($random(seed)) % 4);
    ara <= a;
    arv <= 1'b1;
    do
    begin
      @(posedge aclk);
      k++;
      if (arr)
        arv <= 1'b0;
      if (k >= dl && rrd !== 1'b1)
        rrd <= 1'b1;
    end while (!(rv === 1'b1 && rrd === 1'b1) && k < 50);
    rrd <= 1'b0;
    rd_v = rdat;
    resp = rr;
    chk(32'(k >= 50), 32'h0);
  endtask
  // Rising edge of the interrupt, stamped in cycles
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    while (irq !== 1'b0 && k < 3000)
    begin
      @(posedge aclk);
      k++;
    end
    while (irq !== 1'b1 && k < 3000)
    begin
      @(posedge aclk);
      k++;
    end
    t = cyc;
    chk(32'(k >= 3000), 32'h0);
  endtask
  task automatic end_of_test;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    seed = 32'hb72b;
    cyc = 0;
    {awv, wv, arv, brd, rrd, awa, ara, wd} = '0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // Reset values, then one unmapped word
    for (int i = 0; i < 10; i++)
    begin
      rd(6'(i * 4));
      chk(rd_v, 32'h0);
      chk({30'h0, resp}, (i < 9) ? 32'h0 : {30'h0, CIT_RESP_SLVERR});
    end
    wr(6'h24, 32'hffffffff);
    chk({30'h0, resp}, {30'h0, CIT_RESP_SLVERR});
    cmp_b = 32'(($random(seed) & 32'h7f) + 1);
    wr(CIT_OFF_CMP_B, cmp_b);
    rd(CIT_OFF_CMP_B);
    chk(rd_v, cmp_b);
    // Clear-on-match period for prescale codes 0 to 4
    for (int s = 0; s < 5; s++)
    begin
      wr(CIT_OFF_COUNT_CTRL, 32'h0);
      wr(CIT_OFF_PRESCALE, 32'(s));
      wr(CIT_OFF_CMP_A, 32'(s + 1));
      wr(CIT_OFF_UNIT_MODE, 32'h1);
      wr(CIT_OFF_OUT_CTRL, 32'h2);
      chk({31'h0, wa}, 32'h0);
      wr(CIT_OFF_OUT_CTRL, 32'h3);
      wr(CIT_OFF_IRQ_STATUS, 32'h7);
      wr(CIT_OFF_IRQ_MASK, 32'h1);
      wr(CIT_OFF_COUNT_CTRL, 32'h1);
      wait_irq(t0);
      if (s == 4)
      begin
        rd(CIT_OFF_COUNTER);
        chk(rd_v, 32'h5);
      end
      repeat (2) @(posedge aclk);
      w0 = wa;
      wr(CIT_OFF_IRQ_STATUS, 32'h1);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'((s + 2) * (8 << s)));
      repeat (2) @(posedge aclk);
      chk({31'h0, wa}, {31'h0, ~w0});
      // Quiet stop: mask, disable, clear both match flags
      wr(CIT_OFF_IRQ_MASK, 32'h0);
      wr(CIT_OFF_COUNT_CTRL, 32'h0);
      wr(CIT_OFF_IRQ_STATUS, 32'h3);
      rd(CIT_OFF_COUNTER);
      chk(rd_v, 32'h0);
      chk({31'h0, irq}, 32'h0);
    end
    // Compare of zero fires only at wrap, with overflow
    wr(CIT_OFF_PRESCALE, 32'h0);
    wr(CIT_OFF_UNIT_MODE, 32'h0);
    wr(CIT_OFF_CMP_A, 32'h0);
    wr(CIT_OFF_IRQ_MASK, 32'h5);
    wr(CIT_OFF_COUNT_CTRL, 32'h1);
    n = 0;
    repeat (2000)
    begin
      @(posedge aclk);
      if (irq !== 1'b0)
        n++;
    end
    chk(32'(n), 32'h0);
    wait_irq(t0);
    rd(CIT_OFF_IRQ_STATUS);
    chk(rd_v, 32'h7);
    // Free-running interval: handler advances compare a
    wr(CIT_OFF_IRQ_MASK, 32'h1);
    for (int j = 1; j < 4; j++)
    begin
      wr(CIT_OFF_CMP_A, 32'(j * 16));
      wr(CIT_OFF_IRQ_STATUS, 32'h7);
      wait_irq(t1);
      chk(32'(t1 - t0), 32'(16 * 8));
      t0 = t1;
    end
    // Compare written with the stopped counter value
    wr(CIT_OFF_COUNT_CTRL, 32'h0);
    wr(CIT_OFF_OUT_CTRL, 32'h6);
    wr(CIT_OFF_IRQ_STATUS, 32'h7);
    w0 = wb;
    wr(CIT_OFF_CMP_B, 32'h0);
    repeat (20) @(posedge aclk);
    rd(CIT_OFF_IRQ_STATUS);
    chk(rd_v, 32'h0);
    chk({31'h0, wb}, {31'h0, w0});
    // Register model against read back
    for (int i = 0; i < 9; i++)
    begin
      rd(6'(i * 4));
      if (i != 6 && i != 7)
        chk(rd_v, 32'(mdl[i]));
    end
    // Reset with the counter stopped
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({29'h0, irq, wa, wb}, 32'h3);
    rd(CIT_OFF_COUNT_CTRL);
    chk(rd_v, 32'h0);
    rd(CIT_OFF_COUNTER);
    chk(rd_v, 32'h0);
    end_of_test;
  end
endmodule // tb_top
